// >>> common/modulo_loop_pkg.sv
// Constants and types shared by the modulo loop branch unit.
package modulo_loop_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] LOOP_COUNT_OFS = 8'h00;
  localparam logic [7:0] EPILOG_OFS     = 8'h04;
  localparam logic [7:0] CUR_FRAME_OFS  = 8'h08;
  localparam logic [7:0] PREV_FRAME_OFS = 8'h0c;
  localparam logic [7:0] INTR_FRAME_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS     = 8'h14;

  // Status register bit positions.
  localparam int STAT_FAULT_BIT   = 0;
  localparam int STAT_LC_ZERO_BIT = 1;
  localparam int STAT_EC_ZERO_BIT = 2;
  localparam int STAT_LAST_TK_BIT = 3;

  // Widths, sizes and reset values.
  localparam int         EC_W        = 6;
  localparam logic [31:0] LC_RST     = 32'h0000_0000;
  localparam logic [5:0] EC_RST      = 6'h00;
  localparam logic [5:0] EC_ONE      = 6'h01;
  localparam logic [6:0] FR_ROT_SIZE = 7'h60;
  localparam logic [6:0] PR_ROT_SIZE = 7'h30;
  localparam logic [1:0] LOOP_SLOT   = 2'h2;

  // Instructions seen by the unit.
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_COND = 4'h1, OP_CALL = 4'h2, OP_RET = 4'h3,
    OP_CTOP = 4'h4, OP_CEXIT = 4'h5, OP_WTOP = 4'h6, OP_WEXIT = 4'h7,
    OP_CLRRRB = 4'h8, OP_CLEAR_PREDICATE_ROTATION = 4'h9, OP_COVER = 4'ha,
    OP_RFI = 4'hb, OP_BRP = 4'hc
  } op_t;

  // Strategy hint on branches.
  typedef enum logic [1:0] {
    WH_SPNT = 2'h0, WH_SPTK = 2'h1, WH_DPNT = 2'h2, WH_DPTK = 2'h3
  } whether_t;

  // Strategy hint on branch-predict instructions.
  typedef enum logic [1:0] {
    BW_SPTK = 2'h0, BW_LOOP_POS = 2'h1, BW_DPTK = 2'h2, BW_LOOP_NEG = 2'h3
  } brp_whether_t;

  // Frame marker word; the first field is the top bit.
  typedef struct packed {
    logic       valid;
    logic [2:0] rsvd3;
    logic [3:0] sor;
    logic [1:0] rsvd2;
    logic [5:0] rrb_pr;
    logic       rsvd1;
    logic [6:0] rrb_fr;
    logic       rsvd0;
    logic [6:0] rrb_gr;
  } frame_t;

  // One instruction from the issue stage.
  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [1:0]  slot;
    logic        qp;
    logic [1:0]  wh;
    logic        many;
    logic        clr;
    logic        imp;
    logic        ind;
    logic [2:0]  breg;
    logic [31:0] ip;
    logic [20:0] disp;
    logic [8:0]  loc;
  } issue_t;

  // Resolved branch and hint information.
  typedef struct packed {
    logic         valid;
    logic         taken;
    logic         fault;
    logic         p63_we;
    logic         p63_val;
    logic         pred_taken;
    logic         pred_alloc;
    logic         pred_dyn;
    logic         pf_many;
    logic         dealloc;
    logic         hint_valid;
    logic         hint_ind;
    logic         hint_imp;
    brp_whether_t hint_strat;
    logic [2:0]   hint_breg;
    logic [31:0]  hint_loc;
    logic [31:0]  hint_tgt;
  } result_t;

  // Clears reserved bits of a written frame word.
  function automatic frame_t clean_frame(input logic [31:0] w,
                                         input logic keep_v);
    frame_t f;
    f = frame_t'(w);
    f.rsvd3 = 3'h0;
    f.rsvd2 = 2'h0;
    f.rsvd1 = 1'b0;
    f.rsvd0 = 1'b0;
    f.valid = w[31] & keep_v;
    return f;
  endfunction : clean_frame

endpackage : modulo_loop_pkg

// >>> hdl/modulo_loop_branch_unit.sv
// Loop branch resolution, rotating base control and hint decoding.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Clear, call and cover zero all bases; predicate clear zeroes one.
// [RULE2] Return copies base fields from previous into current frame.
// [RULE3] Top form: taken continues the loop, not-taken leaves it.
// [RULE4] Exit form: not-taken continues the loop, taken leaves it.
// [RULE5] Counted branch direction uses form and both counts, not predicate.
// [RULE6] Nonzero loop count: continue, decrement it, rotate, stage one.
// [RULE7] Every loop branch writes its stage value into predicate 63.
// [RULE8] Counted, zero count, epilog above one: continue, decrement, rotate.
// [RULE9] Counted, zero count, epilog one: exit, decrement, rotate, zero.
// [RULE10] Counted, both counts zero: exit, nothing changes, write zero.
// [RULE11] While with predicate one: continue, rotate, epilog and count kept.
// [RULE12] While, predicate zero, epilog above one: continue, decrement.
// [RULE13] While, predicate zero, epilog one: exit, decrement, rotate.
// [RULE14] While, predicate zero, epilog zero: exit, nothing rotates.
// [RULE15] Hints never alter architectural state and may be ignored.
// [RULE16] Four strategy encodings, static or dynamic, each with default.
// [RULE17] Loop branches are predicted from the two counts.
// [RULE18] Prefetch hint chooses a short or a long target prefetch.
// [RULE19] Deallocation hint keeps or releases the prediction entry.
// [RULE20] Predict instruction locates its branch by bundle plus offset.
// [RULE21] Relative target is bundle plus 21-bit offset; indirect names a BR.
// [RULE22] Predict strategy: static taken, one dynamic, two loop kinds.
// [RULE23] Bases decrement modulo their region; GR only with nonzero size.
// [RULE24] Loop branches outside slot 2 fault as illegal operations.
// [RULE25] All effects of one loop branch commit on the same edge.
module modulo_loop_branch_unit (
  // Clock and reset.
  input  wire logic                    CORE_CLK,
  input  wire logic                    SYS_RST,
  // APB slave.
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic [31:0]                  PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Issue port from the decode stage.
  input  wire modulo_loop_pkg::issue_t ISSUE,
  // Resolved branch and frame state.
  output modulo_loop_pkg::result_t     RESULT,
  output modulo_loop_pkg::frame_t      CUR_FRAME
);
  import modulo_loop_pkg::*;

  logic [31:0]     lc_reg;
  logic [EC_W-1:0] ec_reg;
  frame_t          cfm_reg;
  frame_t          pfm_reg;
  frame_t          ifm_reg;
  logic            fault_reg;
  logic            last_tk_reg;
  result_t         res_next;
  logic [31:0]     rdata_next;
  logic            rerr_next;
  logic            counted;
  logic            whilel;
  logic            is_loop;
  logic            is_top;
  logic            cont;
  logic            dec_lc;
  logic            dec_ec;
  logic            rot;
  logic            stage;
  logic            loop_tk;
  logic            fault;
  logic            commit;
  logic            apb_wr;
  logic [6:0]      gr_size;

  // Decrement a base, wrapping at the size of its region.
  function automatic logic [6:0] rot_dec(input logic [6:0] v,
                                         input logic [6:0] size);
    return (v == 7'h00) ? size - 7'h01 : v - 7'h01; // [RULE23]
  endfunction : rot_dec

  // Sign-extends a 21-bit displacement and adds it to a bundle address.
  function automatic logic [31:0] rel_add(input logic [31:0] ip,
                                          input logic [20:0] d);
    return ip + {{11{d[20]}}, d};
  endfunction : rel_add

  // Instruction class.
  assign counted = (ISSUE.op == OP_CTOP) || (ISSUE.op == OP_CEXIT);
  assign whilel  = (ISSUE.op == OP_WTOP) || (ISSUE.op == OP_WEXIT);
  assign is_loop = counted || whilel;
  assign is_top  = (ISSUE.op == OP_CTOP) || (ISSUE.op == OP_WTOP);
  assign gr_size = {cfm_reg.sor, 3'b000};

  // A misplaced loop branch changes nothing and only reports the fault.
  assign fault  = ISSUE.valid && is_loop && (ISSUE.slot != LOOP_SLOT); // [RULE24]
  assign commit = ISSUE.valid && !fault;
  assign apb_wr = PSEL && PENABLE && PWRITE && PREADY;

  // Loop outcome; the predicate never enters the counted case.
  always_comb begin
    cont   = 1'b0;
    dec_lc = 1'b0;
    dec_ec = 1'b0;
    rot    = 1'b0;
    stage  = 1'b0;
    if (counted && (lc_reg != 32'h0000_0000)) begin // [RULE5]
      cont   = 1'b1; // [RULE6]
      dec_lc = 1'b1;
      rot    = 1'b1;
      stage  = 1'b1;
    end else if (whilel && ISSUE.qp) begin
      cont = 1'b1; // [RULE11]
      rot  = 1'b1;
    end else if (is_loop) begin
      if (ec_reg > EC_ONE) begin
        cont   = 1'b1; // [RULE8] [RULE12]
        dec_ec = 1'b1;
        rot    = 1'b1;
      end else if (ec_reg == EC_ONE) begin
        dec_ec = 1'b1; // [RULE9] [RULE13]
        rot    = 1'b1;
      end
      // Epilog count zero here leaves everything as it is. [RULE10] [RULE14]
    end
  end

  // Direction follows the form of the branch.
  assign loop_tk = is_top ? cont : !cont; // [RULE3] [RULE4]

  // Loop count; a branch update wins over a bus write in the same cycle.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      lc_reg <= LC_RST;
    end else if (commit && dec_lc) begin
      lc_reg <= lc_reg - 32'h0000_0001; // [RULE25]
    end else if (apb_wr && (PADDR == LOOP_COUNT_OFS)) begin
      lc_reg <= PWDATA;
    end
  end

  // Epilog count.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ec_reg <= EC_RST;
    end else if (commit && dec_ec) begin
      ec_reg <= ec_reg - EC_ONE; // [RULE25]
    end else if (apb_wr && (PADDR == EPILOG_OFS)) begin
      ec_reg <= PWDATA[EC_W-1:0];
    end
  end

  // Current frame marker and its rotating bases.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cfm_reg <= '0;
    end else if (commit && rot) begin
      if (cfm_reg.sor != 4'h0) begin
        cfm_reg.rrb_gr <= rot_dec(cfm_reg.rrb_gr, gr_size); // [RULE23]
      end
      cfm_reg.rrb_fr <= rot_dec(cfm_reg.rrb_fr, FR_ROT_SIZE);
      cfm_reg.rrb_pr <= 6'(rot_dec({1'b0, cfm_reg.rrb_pr}, PR_ROT_SIZE));
    end else if (commit && ((ISSUE.op == OP_CLRRRB) ||
                            (ISSUE.op == OP_COVER) ||
                            ((ISSUE.op == OP_CALL) && ISSUE.qp))) begin
      cfm_reg.rrb_gr <= 7'h00; // [RULE1]
      cfm_reg.rrb_fr <= 7'h00;
      cfm_reg.rrb_pr <= 6'h00;
    end else if (commit && (ISSUE.op == OP_CLEAR_PREDICATE_ROTATION)) begin
      cfm_reg.rrb_pr <= 6'h00; // [RULE1]
    end else if (commit && (ISSUE.op == OP_RET) && ISSUE.qp) begin
      cfm_reg.rrb_gr <= pfm_reg.rrb_gr; // [RULE2]
      cfm_reg.rrb_fr <= pfm_reg.rrb_fr;
      cfm_reg.rrb_pr <= pfm_reg.rrb_pr;
    end else if (commit && (ISSUE.op == OP_RFI) && ifm_reg.valid) begin
      cfm_reg.rrb_gr <= ifm_reg.rrb_gr; // [RULE1]
      cfm_reg.rrb_fr <= ifm_reg.rrb_fr;
      cfm_reg.rrb_pr <= ifm_reg.rrb_pr;
    end else if (apb_wr && (PADDR == CUR_FRAME_OFS)) begin
      cfm_reg <= clean_frame(PWDATA, 1'b0);
    end
  end

  // Previous frame marker; a taken call saves the current frame.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pfm_reg <= '0;
    end else if (commit && (ISSUE.op == OP_CALL) && ISSUE.qp) begin
      pfm_reg <= cfm_reg;
    end else if (apb_wr && (PADDR == PREV_FRAME_OFS)) begin
      pfm_reg <= clean_frame(PWDATA, 1'b0);
    end
  end

  // Interruption frame marker is written by software only.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ifm_reg <= '0;
    end else if (apb_wr && (PADDR == INTR_FRAME_OFS)) begin
      ifm_reg <= clean_frame(PWDATA, 1'b1);
    end
  end

  // Sticky fault flag; a new fault wins over a write-one clear.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      fault_reg <= 1'b0;
    end else if (fault) begin
      fault_reg <= 1'b1;
    end else if (apb_wr && (PADDR == STATUS_OFS) &&
                 PWDATA[STAT_FAULT_BIT]) begin
      fault_reg <= 1'b0;
    end
  end

  // Direction of the last committed loop branch, for software to inspect.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      last_tk_reg <= 1'b0;
    end else if (commit && is_loop) begin
      last_tk_reg <= loop_tk;
    end
  end

  // Result word; hints reach only the prediction fields.
  always_comb begin
    res_next            = '0;
    res_next.valid      = ISSUE.valid;
    res_next.fault      = fault;
    res_next.pf_many    = ISSUE.many; // [RULE18]
    res_next.dealloc    = ISSUE.clr; // [RULE19]
    if (!fault && is_loop) begin
      res_next.taken      = loop_tk;
      res_next.p63_we     = 1'b1; // [RULE7]
      res_next.p63_val    = stage;
      res_next.pred_taken = loop_tk; // [RULE17]
      res_next.pred_alloc = 1'b1;
    end else if (!fault && (ISSUE.op == OP_BRP)) begin
      res_next.hint_valid = 1'b1;
      res_next.hint_imp   = ISSUE.imp;
      res_next.hint_ind   = ISSUE.ind;
      res_next.hint_strat = brp_whether_t'(ISSUE.wh); // [RULE22]
      res_next.hint_loc   = ISSUE.ip + {23'h000000, ISSUE.loc}; // [RULE20]
      if (ISSUE.ind) begin
        res_next.hint_breg = ISSUE.breg; // [RULE21]
      end else begin
        res_next.hint_tgt = rel_add(ISSUE.ip, ISSUE.disp); // [RULE21]
      end
    end else if (ISSUE.op inside {OP_COND, OP_CALL, OP_RET}) begin
      res_next.taken = ISSUE.qp; // [RULE15]
      unique case (whether_t'(ISSUE.wh))
        WH_SPNT: res_next.pred_taken = 1'b0; // [RULE16]
        WH_SPTK: res_next.pred_taken = 1'b1;
        WH_DPNT: begin
          res_next.pred_alloc = 1'b1;
          res_next.pred_dyn   = 1'b1;
        end
        WH_DPTK: begin
          res_next.pred_taken = 1'b1;
          res_next.pred_alloc = 1'b1;
          res_next.pred_dyn   = 1'b1;
        end
      endcase
    end
  end

  // Result register, committed on the same edge as the state.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RESULT <= '0;
    end else begin
      RESULT <= res_next; // [RULE25]
    end
  end

  assign CUR_FRAME = cfm_reg;

  // Read mux; an unmapped address reads zero with an error.
  always_comb begin
    rdata_next = 32'h0000_0000;
    rerr_next  = 1'b0;
    unique case (PADDR)
      LOOP_COUNT_OFS: rdata_next = lc_reg;
      EPILOG_OFS:     rdata_next = {26'h0000000, ec_reg};
      CUR_FRAME_OFS:  rdata_next = cfm_reg;
      PREV_FRAME_OFS: rdata_next = pfm_reg;
      INTR_FRAME_OFS: rdata_next = ifm_reg;
      STATUS_OFS: begin
        rdata_next[STAT_FAULT_BIT]   = fault_reg;
        rdata_next[STAT_LC_ZERO_BIT] = (lc_reg == 32'h0000_0000);
        rdata_next[STAT_EC_ZERO_BIT] = (ec_reg == EC_RST);
        rdata_next[STAT_LAST_TK_BIT] = last_tk_reg;
      end
      default: rerr_next = 1'b1;
    endcase
  end

  // APB answer: ready in the first access cycle, so no wait states.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PREADY  <= 1'b1;
      PSLVERR <= rerr_next;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rdata_next;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
  end

  // Clearing all bases leaves every base at zero one edge later.
  clear_all_a: // [RULE1]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && (ISSUE.op == OP_CLRRRB) && !apb_wr
    |=> (cfm_reg.rrb_gr == 7'h00) && (cfm_reg.rrb_fr == 7'h00) &&
        (cfm_reg.rrb_pr == 6'h00))
  else $error("bases not cleared");

  // A taken return restores the FR and PR bases saved in the previous frame.
  ret_copy_a: // [RULE2]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && (ISSUE.op == OP_RET) && ISSUE.qp
    |=> (cfm_reg.rrb_fr == $past(pfm_reg.rrb_fr)) &&
        (cfm_reg.rrb_pr == $past(pfm_reg.rrb_pr)))
  else $error("return did not restore bases");

  // Top form with work left reports taken.
  top_taken_a: // [RULE3]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && (ISSUE.op == OP_CTOP) && (lc_reg != 32'h0000_0000)
    |=> RESULT.taken && RESULT.p63_we && RESULT.p63_val)
  else $error("top branch not taken");

  // Exit form in the last epilog step reports taken.
  exit_taken_a: // [RULE4]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && (ISSUE.op == OP_CEXIT) && (lc_reg == 32'h0000_0000) &&
    (ec_reg == EC_ONE) |=> RESULT.taken && !RESULT.p63_val)
  else $error("exit branch direction wrong");

  // Kernel iteration decrements the loop count by exactly one.
  kernel_dec_a: // [RULE6]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && counted && !apb_wr && (lc_reg != 32'h0000_0000)
    |=> (lc_reg == $past(lc_reg) - 32'h0000_0001) && $stable(ec_reg))
  else $error("loop count not decremented");

  // Last epilog step still rotates the floating-point base.
  epilog_end_a: // [RULE9]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && is_loop && !(whilel && ISSUE.qp) && !apb_wr &&
    (lc_reg == 32'h0000_0000) && (ec_reg == EC_ONE)
    |=> (ec_reg == EC_RST) &&
        (cfm_reg.rrb_fr == rot_dec($past(cfm_reg.rrb_fr), FR_ROT_SIZE)))
  else $error("epilog end did not rotate");

  // An empty loop leaves counts and bases alone and writes zero.
  // The exit form reports taken here, the top form not-taken.
  empty_loop_a: // [RULE10]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && counted && !apb_wr && (lc_reg == 32'h0000_0000) &&
    (ec_reg == EC_RST)
    |=> $stable(lc_reg) && $stable(ec_reg) && $stable(cfm_reg) &&
        RESULT.p63_we && !RESULT.p63_val &&
        (RESULT.taken == ($past(ISSUE.op) == OP_CEXIT)))
  else $error("empty loop changed state");

  // A while kernel step keeps both counts.
  while_kernel_a: // [RULE11]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    commit && whilel && ISSUE.qp && !apb_wr
    |=> $stable(lc_reg) && $stable(ec_reg) && !RESULT.p63_val)
  else $error("while kernel touched counts");

  // A misplaced loop branch faults and changes no state.
  slot_fault_a: // [RULE24]
  assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ISSUE.valid && is_loop && (ISSUE.slot != LOOP_SLOT) && !apb_wr
    |=> RESULT.fault && !RESULT.p63_we && $stable(lc_reg) &&
        $stable(cfm_reg) && fault_reg)
  else $error("slot fault missing");

endmodule : modulo_loop_branch_unit

// >>> tb/issue_source_model.sv
// Decode-stage model that hands one instruction at a time to the unit.
`timescale 1ns/1ps
module issue_source_model (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Request from the bench.
  input  wire logic                    go,
  input  wire modulo_loop_pkg::issue_t req,
  // Issue port towards the unit.
  output modulo_loop_pkg::issue_t      issue
);
  import modulo_loop_pkg::*;

  // Idle cycles show scrambled fields, so a stale field is never trusted.
  always_ff @(posedge clk) begin
    if (rst) begin
      issue <= '0;
    end else if (go) begin
      issue       <= req;
      issue.valid <= 1'b1;
    end else begin
      issue       <= issue_t'(~issue);
      issue.valid <= 1'b0;
    end
  end
endmodule : issue_source_model

// >>> tb/tb_top.sv
// Self-checking bench for the modulo loop branch unit.
`timescale 1ns/1ps
module tb_top;
  import modulo_loop_pkg::*;

  // One counted or while loop case and what it should leave behind.
  typedef struct packed {
    op_t         op;
    logic        qp;
    logic [31:0] lc;
    logic [5:0]  ec;
    logic        tk;
    logic        p63;
    logic        rot;
    logic [31:0] elc;
    logic [5:0]  eec;
  } row_t;

  // Frame words: sor of one gives a general rotating region of eight.
  localparam logic [31:0] F0 = 32'h0100_0000;
  localparam logic [31:0] FR = 32'h012f_5f07;
  localparam logic [31:0] FB = 32'h0105_0a03;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        go;
  issue_t      req;
  issue_t      issue;
  result_t     result;
  frame_t      cur_frame;
  logic [31:0] rdv;
  logic        errv;
  issue_t      r;
  row_t        rows [9];
  op_t         clr_ops [4];
  logic [31:0] clr_exp [4];
  int          bad_count = 0;
  int          cmp_count = 0;

  modulo_loop_branch_unit modulo_loop_branch_unit_i (
    .CORE_CLK  (clk),
    .SYS_RST   (rst),
    .PSEL      (psel),
    .PENABLE   (penable),
    .PWRITE    (pwrite),
    .PADDR     (paddr),
    .PWDATA    (pwdata),
    .PRDATA    (prdata),
    .PREADY    (pready),
    .PSLVERR   (pslverr),
    .ISSUE     (issue),
    .RESULT    (result),
    .CUR_FRAME (cur_frame)
  );

  issue_source_model issue_source_model_i (
    .clk   (clk),
    .rst   (rst),
    .go    (go),
    .req   (req),
    .issue (issue)
  );

  // Free-running core clock at 125 MHz.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Hands one instruction to the decode model; result is checked after.
  task automatic send(input issue_t ri);
    @(posedge clk);
    go  <= 1'b1;
    req <= ri;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk(result.valid, 1'b1);
  endtask : send

  function automatic issue_t mk(input op_t op, input logic qp);
    issue_t ri;
    ri = '0;
    ri.op = op;
    ri.qp = qp;
    ri.slot = LOOP_SLOT;
    return ri;
  endfunction : mk

  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog far beyond the few hundred cycles the run needs.
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end

  // Main sequence: table of loop cases first, then the awkward ones.
  initial begin
    rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    go <= 1'b0;
    req <= '0;
    rows[0] = '{OP_CTOP, 1'b0, 32'h5, 6'h3, 1'b1, 1'b1, 1'b1, 32'h4, 6'h3};
    rows[1] = '{OP_CEXIT, 1'b1, 32'h5, 6'h3, 1'b0, 1'b1, 1'b1, 32'h4, 6'h3};
    rows[2] = '{OP_CTOP, 1'b1, 32'h0, 6'h3, 1'b1, 1'b0, 1'b1, 32'h0, 6'h2};
    rows[3] = '{OP_CTOP, 1'b0, 32'h0, 6'h1, 1'b0, 1'b0, 1'b1, 32'h0, 6'h0};
    rows[4] = '{OP_CEXIT, 1'b0, 32'h0, 6'h0, 1'b1, 1'b0, 1'b0, 32'h0, 6'h0};
    rows[5] = '{OP_WTOP, 1'b1, 32'h7, 6'h3, 1'b1, 1'b0, 1'b1, 32'h7, 6'h3};
    rows[6] = '{OP_WEXIT, 1'b0, 32'h7, 6'h2, 1'b0, 1'b0, 1'b1, 32'h7, 6'h1};
    rows[7] = '{OP_WTOP, 1'b0, 32'h0, 6'h1, 1'b0, 1'b0, 1'b1, 32'h0, 6'h0};
    rows[8] = '{OP_WEXIT, 1'b0, 32'h2, 6'h0, 1'b1, 1'b0, 1'b0, 32'h2, 6'h0};
    clr_ops = '{OP_CLRRRB, OP_CLEAR_PREDICATE_ROTATION, OP_COVER, OP_CALL};
    clr_exp = '{F0, 32'h0100_0a03, F0, F0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(cur_frame, 32'h0);
    chk(result.valid, 1'b0);
    // Every counted and while loop outcome, from a frame with zero bases.
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, LOOP_COUNT_OFS, rows[i].lc);
      apb(1'b1, EPILOG_OFS, {26'h0, rows[i].ec});
      apb(1'b1, CUR_FRAME_OFS, F0);
      send(mk(rows[i].op, rows[i].qp));
      chk(result.taken, rows[i].tk);
      chk(result.pred_taken, rows[i].tk);
      chk({result.p63_we, result.p63_val}, {1'b1, rows[i].p63});
      chk(cur_frame, rows[i].rot ? FR : F0);
      apb(1'b0, LOOP_COUNT_OFS, 32'h0);
      chk(rdv, rows[i].elc);
      apb(1'b0, EPILOG_OFS, 32'h0);
      chk(rdv, {26'h0, rows[i].eec});
    end
    // Clearing forms, each from a frame with all bases nonzero.
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, CUR_FRAME_OFS, FB);
      send(mk(clr_ops[k], 1'b1));
      chk(cur_frame, clr_exp[k]);
    end
    apb(1'b1, PREV_FRAME_OFS, 32'h0107_0908);
    send(mk(OP_RET, 1'b1));
    chk(cur_frame, 32'h0107_0908);
    apb(1'b1, INTR_FRAME_OFS, 32'h8102_0304);
    send(mk(OP_RFI, 1'b1));
    chk(cur_frame, 32'h0102_0304);
    apb(1'b1, INTR_FRAME_OFS, 32'h0105_0607);
    send(mk(OP_RFI, 1'b1));
    chk(cur_frame, 32'h0102_0304);
    // Loop branches in slots zero and one fault and change nothing.
    apb(1'b1, LOOP_COUNT_OFS, 32'h5);
    apb(1'b1, CUR_FRAME_OFS, F0);
    for (int s = 0; s < 2; s++) begin
      r = mk(OP_CTOP, 1'b0);
      r.slot = s[1:0];
      send(r);
      chk(result.fault, 1'b1);
      chk(cur_frame, F0);
    end
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv[STAT_FAULT_BIT], 1'b1);
    apb(1'b1, STATUS_OFS, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv[STAT_FAULT_BIT], 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk({errv, rdv}, {1'b1, 32'h0});
    // All four strategy hints with prefetch and deallocation variations.
    for (int w = 0; w < 4; w++) begin
      r = mk(OP_COND, 1'b1);
      r.wh = w[1:0];
      r.many = w[0];
      r.clr = w[1];
      r.ip = 32'h2000 + 32'(w * 16);
      send(r);
      chk({result.pred_alloc, result.pred_dyn}, {2{w[1]}});
      chk(result.pred_taken, w[0]);
      chk({result.pf_many, result.dealloc}, {w[0], w[1]});
    end
    chk(cur_frame, F0);
    apb(1'b0, LOOP_COUNT_OFS, 32'h0);
    chk(rdv, 32'h5);
    // Branch-predict: relative with a negative offset, then indirect.
    r = mk(OP_BRP, 1'b1);
    r.ip = 32'h1000;
    r.loc = 9'h40;
    r.disp = 21'h1ffff0;
    r.wh = 2'h3;
    r.imp = 1'b1;
    send(r);
    chk({result.hint_valid, result.hint_imp}, 2'h3);
    chk(result.hint_loc, 32'h1040);
    chk(result.hint_tgt, 32'h0ff0);
    chk(result.hint_strat, BW_LOOP_NEG);
    r.ind = 1'b1;
    r.breg = 3'h5;
    r.wh = 2'h1;
    send(r);
    chk({result.hint_breg, result.hint_tgt}, {3'h5, 32'h0});
    chk(result.hint_strat, BW_LOOP_POS);
    tally_and_finish();
  end
endmodule : tb_top
